// ### sbr_pkg.sv
// Constants for the scanned BCD readout port.
// Assumes a 50 MHz system clock.
package sbr_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NUM_DIGITS = 6;
  localparam int SLOT_W = 3;
  localparam int SCAN_PERIOD_NS = 500000;
  localparam int SCAN_HALF_CYC = SCAN_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int BLINK_PERIOD_NS = 333333333;
  localparam int BLINK_HALF_CYC = BLINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int TB_PERIOD_NS = 1000;
  localparam int TB_HALF_CYC = TB_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int PWRUP_PULSE_NS = 2000;
  localparam int PWRUP_CYC = (PWRUP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_STATE = 4'hc;
  localparam int CTRL_TB_EXT_BIT = 0;
  localparam int EV_W = 4;
  localparam int EV_FRAME = 0;
  localparam int EV_BLANK = 1;
  localparam int EV_CLEAR = 2;
  localparam int EV_OVF = 3;
  localparam logic [3:0] BCD_MARKER = 4'hf;
  localparam int PIN_W = 5;
  localparam int PIN_SCAN_EN = 0;
  localparam int PIN_OVF = 1;
  localparam int PIN_GATE = 2;
  localparam int PIN_RST = 3;
  localparam int PIN_TB = 4;
endpackage

// ### sbr_div_if.sv
// Handshake between the readout top and its clock divider.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
`default_nettype none
interface sbr_div_if;
  logic run;
  logic level;
  logic rise;
  modport ctrl (output run, input level, input rise);
  modport div (input run, output level, output rise);
endinterface
`default_nettype wire

// ### sbr_divider.sv
// Square-wave divider with a rising-edge pulse.
// Assumes run comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sbr_divider #(
  parameter int HALF = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  sbr_div_if.div dv
);
  localparam int CW = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);
  logic [CW-1:0] cnt_ff;
  logic level_ff;

  // Stops and parks low while not running
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !dv.run) begin
      cnt_ff <= '0;
      level_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
      level_ff <= ~level_ff;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign dv.level = level_ff;
  // Marks the very edge on which level goes high
  assign dv.rise = i_rst_n && dv.run && (cnt_ff == LAST) && !level_ff;
endmodule
`default_nettype wire

// ### sbr_readout_port.sv
// Scanned BCD readout port of a counter instrument, with its rear control lines.
// Assumes digits and overflow come from the counter core on i_clk_sys;
// all pins are asynchronous and pass two flip-flops.
`timescale 1ns/100ps
`default_nettype none
module sbr_readout_port #(
  parameter int NUM_DIGITS = sbr_pkg::NUM_DIGITS,
  parameter int SCAN_HALF_CYC = sbr_pkg::SCAN_HALF_CYC,
  parameter int BLINK_HALF_CYC = sbr_pkg::BLINK_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [sbr_pkg::ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  input wire logic [4*NUM_DIGITS-1:0] i_digits,
  input wire logic i_overflow,
  input wire logic i_scan_enable,
  output logic o_scan_clk,
  output logic o_scan_frame_marker_n,
  output logic [3:0] o_bcd,
  input wire logic i_ovf_line,
  output logic o_ovf_line_out,
  output logic o_ovf_line_oe,
  output logic o_display_blank,
  input wire logic i_tb_line,
  output logic o_tb_line_out,
  output logic o_tb_line_oe,
  output logic o_timebase_tick,
  input wire logic i_manual_gate_n,
  output logic o_count_gate_open,
  input wire logic i_reset_line,
  output logic o_reset_line_out,
  output logic o_reset_line_oe,
  output logic o_counter_clear
);
  localparam int SW = sbr_pkg::SLOT_W;
  localparam logic [SW-1:0] LAST_SLOT = SW'(NUM_DIGITS);
  localparam int PW = $clog2(sbr_pkg::PWRUP_CYC + 1);
  localparam logic [PW-1:0] PWRUP_LAST = PW'(sbr_pkg::PWRUP_CYC);

  // Digit of a slot; slot 1 is the most significant digit
  function automatic logic [3:0] slot_digit(input logic [4*NUM_DIGITS-1:0] d,
                                            input logic [SW-1:0] s);
    logic [3:0] r;
    r = sbr_pkg::BCD_MARKER;
    for (int k = 1; k <= NUM_DIGITS; k++) begin
      if (s == SW'(k)) begin
        r = d[4*(NUM_DIGITS-k) +: 4];
      end
    end
    return r;
  endfunction

  // Slot shows a zero with only zeros to its left, last digit excepted
  function automatic logic slot_lz(input logic [4*NUM_DIGITS-1:0] d,
                                   input logic [SW-1:0] s);
    logic lead;
    logic r;
    lead = 1'b1;
    r = 1'b0;
    for (int k = 1; k <= NUM_DIGITS; k++) begin
      lead = lead & (d[4*(NUM_DIGITS-k) +: 4] == 4'h0);
      if (s == SW'(k) && k < NUM_DIGITS) begin
        r = lead;
      end
    end
    return r;
  endfunction

  // Pin synchronisers
  logic [sbr_pkg::PIN_W-1:0] pin_raw;
  logic [sbr_pkg::PIN_W-1:0] pin_s1_ff;
  logic [sbr_pkg::PIN_W-1:0] pin_s2_ff;
  assign pin_raw[sbr_pkg::PIN_SCAN_EN] = i_scan_enable;
  assign pin_raw[sbr_pkg::PIN_OVF] = i_ovf_line;
  assign pin_raw[sbr_pkg::PIN_GATE] = i_manual_gate_n;
  assign pin_raw[sbr_pkg::PIN_RST] = i_reset_line;
  assign pin_raw[sbr_pkg::PIN_TB] = i_tb_line;

  genvar gi;
  generate
    for (gi = 0; gi < sbr_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
          pin_s1_ff[gi] <= 1'b1;
          pin_s2_ff[gi] <= 1'b1;
        end else begin
          pin_s1_ff[gi] <= pin_raw[gi];
          pin_s2_ff[gi] <= pin_s1_ff[gi];
        end
      end
    end
  endgenerate

  logic scan_en;
  logic ovf_line;
  logic gate_n;
  logic rst_line;
  logic tb_in;
  assign scan_en = pin_s2_ff[sbr_pkg::PIN_SCAN_EN];
  assign ovf_line = pin_s2_ff[sbr_pkg::PIN_OVF];
  assign gate_n = pin_s2_ff[sbr_pkg::PIN_GATE];
  assign rst_line = pin_s2_ff[sbr_pkg::PIN_RST];
  assign tb_in = pin_s2_ff[sbr_pkg::PIN_TB];

  // Dividers
  sbr_div_if scan_dv();
  sbr_div_if blink_dv();
  sbr_div_if tb_dv();

  assign scan_dv.run = scan_en;
  assign blink_dv.run = i_overflow;
  assign tb_dv.run = 1'b1;

  sbr_divider #(.HALF(SCAN_HALF_CYC)) u_scan_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .dv(scan_dv)
  );
  sbr_divider #(.HALF(BLINK_HALF_CYC)) u_blink_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .dv(blink_dv)
  );
  sbr_divider #(.HALF(sbr_pkg::TB_HALF_CYC)) u_tb_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .dv(tb_dv)
  );

  assign o_scan_clk = scan_dv.level;

  // Scan slot sequencer
  logic [SW-1:0] slot_ff;
  logic [SW-1:0] nxt_slot;
  logic [3:0] bcd_ff;
  logic marker_n_ff;
  logic lz_ff;

  always_comb begin
    if (slot_ff == LAST_SLOT) begin
      nxt_slot = '0;
    end else begin
      nxt_slot = slot_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      slot_ff <= LAST_SLOT;
      bcd_ff <= sbr_pkg::BCD_MARKER;
      marker_n_ff <= 1'b1;
      lz_ff <= 1'b0;
    end else if (scan_dv.rise) begin
      slot_ff <= nxt_slot;
      bcd_ff <= slot_digit(i_digits, nxt_slot);
      marker_n_ff <= (nxt_slot != '0);
      lz_ff <= slot_lz(i_digits, nxt_slot);
    end
  end

  assign o_bcd = bcd_ff;
  assign o_scan_frame_marker_n = marker_n_ff;

  // Overflow and leading zero line
  logic ovf_drive_ff;
  logic [2:0] ovf_hist_ff;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ovf_drive_ff <= 1'b0;
    end else if (i_overflow) begin
      ovf_drive_ff <= blink_dv.level;
    end else begin
      ovf_drive_ff <= lz_ff;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ovf_hist_ff <= '0;
    end else begin
      ovf_hist_ff <= {ovf_hist_ff[1:0], ovf_drive_ff};
    end
  end

  assign o_ovf_line_out = 1'b0;
  assign o_ovf_line_oe = ovf_drive_ff;

  // Low line not of our own making blanks the display
  logic blank_ff;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      blank_ff <= 1'b0;
    end else begin
      blank_ff <= !ovf_line && !ovf_drive_ff && (ovf_hist_ff == 3'b000);
    end
  end
  assign o_display_blank = blank_ff;

  // Timebase contact
  logic [31:0] ctrl_ff;
  logic tb_ext;
  logic tb_d_ff;
  logic tick_ff;
  assign tb_ext = ctrl_ff[sbr_pkg::CTRL_TB_EXT_BIT];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tb_d_ff <= 1'b1;
      tick_ff <= 1'b0;
    end else begin
      tb_d_ff <= tb_in;
      tick_ff <= tb_ext ? (tb_in && !tb_d_ff) : tb_dv.rise;
    end
  end

  assign o_tb_line_out = tb_dv.level;
  assign o_tb_line_oe = !tb_ext;
  assign o_timebase_tick = tick_ff;

  // Manual gate
  logic gate_ff;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      gate_ff <= 1'b0;
    end else begin
      gate_ff <= !gate_n;
    end
  end
  assign o_count_gate_open = gate_ff;

  // Reset line: power-up pulse and clear
  logic [PW-1:0] pwr_cnt_ff;
  logic pwr_drive_ff;
  logic clear_ff;
  logic clear_d_ff;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pwr_cnt_ff <= '0;
      pwr_drive_ff <= 1'b1;
    end else if (pwr_cnt_ff == PWRUP_LAST) begin
      pwr_drive_ff <= 1'b0;
    end else begin
      pwr_cnt_ff <= pwr_cnt_ff + 1'b1;
      pwr_drive_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      clear_ff <= 1'b0;
      clear_d_ff <= 1'b0;
    end else begin
      clear_ff <= !rst_line;
      clear_d_ff <= clear_ff;
    end
  end

  assign o_reset_line_out = 1'b0;
  assign o_reset_line_oe = pwr_drive_ff;
  assign o_counter_clear = clear_ff;

  // Events
  logic [sbr_pkg::EV_W-1:0] ev;
  logic ovf_d_ff;
  logic blank_d_ff;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ovf_d_ff <= 1'b0;
      blank_d_ff <= 1'b0;
    end else begin
      ovf_d_ff <= i_overflow;
      blank_d_ff <= blank_ff;
    end
  end

  assign ev[sbr_pkg::EV_FRAME] = scan_dv.rise && (nxt_slot == '0);
  assign ev[sbr_pkg::EV_BLANK] = blank_ff && !blank_d_ff;
  assign ev[sbr_pkg::EV_CLEAR] = clear_ff && !clear_d_ff;
  assign ev[sbr_pkg::EV_OVF] = i_overflow && !ovf_d_ff;

  // Register file
  logic [sbr_pkg::EV_W-1:0] status_ff;
  logic [sbr_pkg::EV_W-1:0] mask_ff;
  logic [sbr_pkg::EV_W-1:0] w1c;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  assign w1c = (i_wr && i_addr == sbr_pkg::ADDR_STATUS) ?
               i_wdata[sbr_pkg::EV_W-1:0] : '0;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl_ff <= '0;
    end else if (i_wr && i_addr == sbr_pkg::ADDR_CTRL) begin
      ctrl_ff <= {31'h0, i_wdata[sbr_pkg::CTRL_TB_EXT_BIT]};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mask_ff <= '0;
    end else if (i_wr && i_addr == sbr_pkg::ADDR_MASK) begin
      mask_ff <= i_wdata[sbr_pkg::EV_W-1:0];
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~w1c) | ev;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (i_addr)
      sbr_pkg::ADDR_CTRL: nxt_rdata = ctrl_ff;
      sbr_pkg::ADDR_STATUS: nxt_rdata = {28'h000_0000, status_ff};
      sbr_pkg::ADDR_MASK: nxt_rdata = {28'h000_0000, mask_ff};
      sbr_pkg::ADDR_STATE: nxt_rdata = {20'h0_0000, bcd_ff, 1'b0, slot_ff,
                                        blank_ff, gate_ff, marker_n_ff,
                                        scan_dv.level};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
    end else if (i_rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= '0;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_irq = |(status_ff & mask_ff);
endmodule
`default_nettype wire

// ### sbr_readout_port_sva.sv
// Checker for the scan link pins and the read port.
// Assumes it is bound onto the readout port top module.
`timescale 1ns/100ps
`default_nettype none
module sbr_readout_port_sva #(
  parameter int SCAN_HALF_CYC = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_scan_enable,
  input wire logic o_scan_clk,
  input wire logic o_scan_frame_marker_n,
  input wire logic [3:0] o_bcd,
  input wire logic o_ovf_line_out,
  input wire logic o_reset_line_out,
  input wire logic i_manual_gate_n,
  input wire logic o_count_gate_open,
  input wire logic i_reset_line,
  input wire logic o_counter_clear
);
  logic sc_ff;
  logic seen_ff;
  int run_ff;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  always_ff @(posedge i_clk_sys) begin
    sc_ff <= o_scan_clk;
  end
  // Cycles since the last scan clock change
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || o_scan_clk != sc_ff) begin
      run_ff <= 0;
    end else begin
      run_ff <= run_ff + 1;
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !i_scan_enable) begin
      seen_ff <= 1'h0;
    end else if (o_scan_clk != sc_ff) begin
      seen_ff <= 1'h1;
    end
  end
  property p_half;
    seen_ff && i_scan_enable && o_scan_clk != sc_ff |-> run_ff == SCAN_HALF_CYC - 1;
  endproperty
  a_half: assert property (p_half) else $error("scan half period wrong");
  property p_stable;
    !$rose(o_scan_clk) |-> $stable(o_bcd);
  endproperty
  a_stable: assert property (p_stable) else $error("bcd moved off a scan rise");
  property p_marker_f;
    !o_scan_frame_marker_n |-> o_bcd == sbr_pkg::BCD_MARKER;
  endproperty
  a_marker_f: assert property (p_marker_f) else $error("bcd not all high in marker");
  property p_marker_edge;
    $changed(o_scan_frame_marker_n) |-> $rose(o_scan_clk);
  endproperty
  a_marker_edge: assert property (p_marker_edge) else $error("marker off a rise");
  property p_stop;
    !i_scan_enable [*4] |-> !o_scan_clk;
  endproperty
  a_stop: assert property (p_stop) else $error("scan clock runs while disabled");
  property p_gate;
    $changed(i_manual_gate_n) |-> ##[1:4] o_count_gate_open == !i_manual_gate_n;
  endproperty
  a_gate: assert property (p_gate) else $error("count gate does not follow pin");
  property p_clear;
    $fell(i_reset_line) |-> ##[1:4] o_counter_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("reset line did not clear");
  property p_rdata;
    !$past(i_rd) |-> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
  property p_odrain;
    o_ovf_line_out == 1'h0 && o_reset_line_out == 1'h0;
  endproperty
  a_odrain: assert property (p_odrain) else $error("open drain drives high");
endmodule
`default_nettype wire

// ### sbr_far_end.sv
// Far-end model that demultiplexes the scanned digits.
// Assumes the scan clock, marker and BCD lines of the readout port.
`timescale 1ns/100ps
`default_nettype none
module sbr_far_end #(
  parameter int NUM_DIGITS = 6
) (
  input wire logic i_scan_clk,
  input wire logic i_marker_n,
  input wire logic [3:0] i_bcd,
  output logic [4*NUM_DIGITS-1:0] o_frame,
  output int o_frames
);
  logic [4*NUM_DIGITS-1:0] acc;
  int idx;
  initial begin
    o_frame = '0;
    o_frames = 0;
    idx = NUM_DIGITS + 1;
  end
  // Listens only, never drives the scan clock line
  // Takes each slot on the falling scan clock edge
  always @(negedge i_scan_clk) begin
    if (!i_marker_n) begin // Marker restarts the digit count
      if (idx == NUM_DIGITS) begin
        o_frame <= acc;
        o_frames <= o_frames + 1;
      end
      idx <= 0;
    end else if (idx < NUM_DIGITS) begin
      acc[4*(NUM_DIGITS-1-idx) +: 4] <= i_bcd; // MSD first, high is one
      idx <= idx + 1;
    end
  end
endmodule
`default_nettype wire

// ### sbr_readout_port_tb_top.sv
// Testbench for the scanned BCD readout port.
// Assumes the package, design, far-end model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module sbr_readout_port_tb_top;
  localparam int HALF = 4;
  logic i_clk_sys = 1'h0;
  logic i_rst_n = 1'h0;
  logic [3:0] i_addr = 4'h0;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'h0;
  logic i_rd = 1'h0;
  logic [23:0] i_digits = 24'h98_1275;
  logic i_overflow = 1'h0;
  logic i_scan_enable = 1'h1;
  logic i_manual_gate_n = 1'h1;
  logic ovf_pull = 1'h0;
  logic rst_pull = 1'h0;
  logic ext_en = 1'h0;
  logic ext_clk = 1'h0;
  logic i_ovf_line, i_reset_line, i_tb_line;
  logic [31:0] o_rdata, rv;
  logic o_irq, o_scan_clk, o_scan_frame_marker_n, o_ovf_line_out, o_ovf_line_oe;
  logic o_display_blank, o_tb_line_out, o_tb_line_oe, o_timebase_tick, o_count_gate_open;
  logic o_reset_line_out, o_reset_line_oe, o_counter_clear;
  logic [3:0] o_bcd;
  logic [23:0] frame;
  int frames, c;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  // Pull-ups on the open-drain lines
  assign i_ovf_line = ~(o_ovf_line_oe | ovf_pull);
  assign i_reset_line = ~(o_reset_line_oe | rst_pull);
  assign i_tb_line = o_tb_line_oe ? o_tb_line_out : ext_clk;
  initial begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  always #80 ext_clk = ext_en & ~ext_clk;
  sbr_readout_port #(.SCAN_HALF_CYC(HALF), .BLINK_HALF_CYC(6)) sbr_readout_port_i (
    .i_clk_sys, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_digits,
    .i_overflow, .i_scan_enable, .o_scan_clk, .o_scan_frame_marker_n, .o_bcd, .i_ovf_line,
    .o_ovf_line_out, .o_ovf_line_oe, .o_display_blank, .i_tb_line, .o_tb_line_out,
    .o_tb_line_oe, .o_timebase_tick, .i_manual_gate_n, .o_count_gate_open, .i_reset_line,
    .o_reset_line_out, .o_reset_line_oe, .o_counter_clear);
  sbr_far_end sbr_far_end_i (.i_scan_clk(o_scan_clk), .i_marker_n(o_scan_frame_marker_n),
    .i_bcd(o_bcd), .o_frame(frame), .o_frames(frames));
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'h1;
    cyc(1);
    i_wr <= 1'h0;
    cyc(1);
  endtask
  task automatic rd_reg(input logic [3:0] a);
    i_addr <= a;
    i_rd <= 1'h1;
    cyc(1);
    rv = o_rdata;
    i_rd <= 1'h0;
    cyc(1);
  endtask
  task automatic wait_val(ref logic s, input logic v);
    for (int k = 0; k < 60 && s !== v; k++) cyc(1);
  endtask
  task automatic next_slot();
    wait_val(o_scan_clk, 1'h0);
    wait_val(o_scan_clk, 1'h1);
    cyc(2);
  endtask
  task automatic wait_frames(input int n);
    int f0;
    f0 = frames;
    for (int k = 0; k < 100 * n && frames < f0 + n; k++) cyc(1);
  endtask
  task automatic count_ticks(input int n);
    c = 0;
    repeat (n) begin
      cyc(1);
      c += int'(o_timebase_tick);
    end
  endtask
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    cyc(8);
    i_rst_n <= 1'h1;
    cyc(1);
    chk_b(o_reset_line_oe, 1'h1);
    cyc(4);
    chk_b(o_counter_clear, 1'h1);
    cyc(sbr_pkg::PWRUP_CYC + 4);
    chk_b(o_reset_line_oe, 1'h0);
    chk_b(o_counter_clear, 1'h0);
    rd_reg(sbr_pkg::ADDR_MASK);
    chk(rv, 32'h0000_0000);
    rd_reg(4'h2);
    chk(rv, 32'h0000_0000);
    wr_reg(sbr_pkg::ADDR_STATUS, 32'h0000_000f);
    // Readout of a full frame, checked once after three whole frames
    wait_frames(3);
    chk(32'(frame), 32'(i_digits));
    rd_reg(sbr_pkg::ADDR_STATUS);
    chk_b(rv[sbr_pkg::EV_FRAME], 1'h1);
    chk_b(o_irq, 1'h0);
    wr_reg(sbr_pkg::ADDR_MASK, 32'h0000_0008);
    wr_reg(sbr_pkg::ADDR_STATUS, 32'h0000_000f);
    chk_b(o_irq, 1'h0);
    // Leading zeros suppressed on the overflow line
    i_digits <= 24'h00_0120;
    wait_val(o_scan_frame_marker_n, 1'h0);
    wait_val(o_scan_frame_marker_n, 1'h1);
    cyc(2);
    chk_b(o_ovf_line_oe, 1'h1);
    repeat (3) next_slot();
    chk_b(o_ovf_line_oe, 1'h0);
    // Overflow blinks the line
    i_overflow <= 1'h1;
    wait_val(o_ovf_line_oe, 1'h1);
    wait_val(o_ovf_line_oe, 1'h0);
    chk_b(o_ovf_line_oe, 1'h0);
    wait_val(o_ovf_line_oe, 1'h1);
    chk_b(o_ovf_line_oe, 1'h1);
    chk_b(o_irq, 1'h1);
    wr_reg(sbr_pkg::ADDR_STATUS, 32'h0000_0008);
    chk_b(o_irq, 1'h0);
    i_overflow <= 1'h0;
    i_digits <= 24'h12_3456;
    cyc(20);
    // Far side blanks the display
    ovf_pull <= 1'h1;
    cyc(8);
    chk_b(o_display_blank, 1'h1);
    rd_reg(sbr_pkg::ADDR_STATUS);
    chk_b(rv[sbr_pkg::EV_BLANK], 1'h1);
    ovf_pull <= 1'h0;
    cyc(8);
    chk_b(o_display_blank, 1'h0);
    // Manual gate
    chk_b(o_count_gate_open, 1'h0);
    i_manual_gate_n <= 1'h0; // Totalize use only
    cyc(5);
    chk_b(o_count_gate_open, 1'h1);
    rd_reg(sbr_pkg::ADDR_STATE);
    chk_b(rv[2], 1'h1);
    i_manual_gate_n <= 1'h1;
    cyc(5);
    chk_b(o_count_gate_open, 1'h0);
    // External reset
    rst_pull <= 1'h1;
    cyc(6);
    chk_b(o_counter_clear, 1'h1);
    rd_reg(sbr_pkg::ADDR_STATUS);
    chk_b(rv[sbr_pkg::EV_CLEAR], 1'h1);
    rst_pull <= 1'h0;
    cyc(6);
    chk_b(o_counter_clear, 1'h0);
    // Timebase contact out, then in
    chk_b(o_tb_line_oe, 1'h1);
    wait_val(o_timebase_tick, 1'h1);
    chk_b(o_tb_line_out, 1'h1);
    count_ticks(500);
    chk(32'(c), 32'(500 / (2 * sbr_pkg::TB_HALF_CYC)));
    ext_en <= 1'h1;
    wr_reg(sbr_pkg::ADDR_CTRL, 32'h0000_0001);
    rd_reg(sbr_pkg::ADDR_CTRL);
    chk(rv, 32'h0000_0001);
    cyc(2);
    chk_b(o_tb_line_oe, 1'h0);
    count_ticks(400);
    chk_b(c >= 49 && c <= 51, 1'h1);
    wr_reg(sbr_pkg::ADDR_CTRL, 32'h0000_0000);
    ext_en <= 1'h0;
    // Scan clock disable
    i_scan_enable <= 1'h0;
    cyc(4);
    c = frames;
    cyc(36);
    chk_b(o_scan_clk, 1'h0);
    chk(32'(frames), 32'(c));
    i_scan_enable <= 1'h1;
    wait_frames(2);
    chk(32'(frame), 32'(i_digits));
    close_out();
  end
endmodule
bind sbr_readout_port sbr_readout_port_sva #(.SCAN_HALF_CYC(SCAN_HALF_CYC)) sbr_sva_i (
  .i_clk_sys, .i_rst_n, .i_rd, .o_rdata, .i_scan_enable, .o_scan_clk, .o_scan_frame_marker_n,
  .o_bcd, .o_ovf_line_out, .o_reset_line_out, .i_manual_gate_n, .o_count_gate_open,
  .i_reset_line, .o_counter_clear);
`default_nettype wire
